// ---- inc/uirq_pkg.sv ----
// Overview of operation
// - Data-ready sets when a character enters the receive FIFO, clears when empty.
// - Line status (code 06) outranks receive data available (code 04).
// - Receive interrupt is raised at trigger level, withdrawn when fill drops below.
// - Time-out fires with data held and no push or pop for four characters.
// - Character times come from the baud tick, so delay scales with baud.
// - Without pending time-out, a pop or a push restarts the timer.
// - A receive FIFO read clears a pending time-out and restarts the timer.
// - Transmit FIFO empty raises code 02; holding write or an ID read showing 02 clears it.
// - Empty indication is delayed one char minus stop bit unless two bytes were held.
// - The first transmit interrupt follows a change of the FIFO enable bit at once.
// - Trigger and time-out share priority two; holding and FIFO empty share three.
// - FIFOs enabled with all interrupts off is polled mode: no time-out or trigger interrupt.
// - Mask bit 0 receive/time-out, bit 1 tx empty, bit 2 line, bit 3 modem.
// - Upper four mask bits always read zero.
// - All mask bits clear suppresses identification and interrupt output.
// - Four priority levels: line, receive/time-out, tx empty, modem.
// - ID register shows highest source; bit 0 low when pending, 0001 when none.
// - ID bits 3 and 2 set for time-out in FIFO mode; bit 3 zero without FIFOs.
// - ID bits 4 and 5 zero; bits 6 and 7 set when FIFOs enabled.
// - Modem interrupt from input changes, cleared by modem status read.
// - Line status from overrun, parity, framing, break; cleared by line status read.
// - Trigger field 00/01/10/11 selects 1/4/8/14 bytes.
// - Line status interrupt needs its enable bit.
package uirq_pkg;
    localparam logic [1:0] UIRQ_ADDR_MASK   = 2'h0;
    localparam logic [1:0] UIRQ_ADDR_ID     = 2'h1;
    localparam logic [1:0] UIRQ_ADDR_STATUS = 2'h2;
    localparam logic [7:0] UIRQ_MASK_RESET  = 8'h00;
    localparam logic [3:0] UIRQ_ID_NONE     = 4'h1;
    localparam logic [3:0] UIRQ_ID_LINE     = 4'h6;
    localparam logic [3:0] UIRQ_ID_RXAVAIL  = 4'h4;
    localparam logic [3:0] UIRQ_ID_TIMEOUT  = 4'hc;
    localparam logic [3:0] UIRQ_ID_TXEMPTY  = 4'h2;
    localparam logic [3:0] UIRQ_ID_MODEM    = 4'h0;
    localparam int         UIRQ_TICKS_PER_BIT = 16;
    localparam int         UIRQ_TIMEOUT_CHARS = 4;
    localparam int         UIRQ_STOP_TICKS    = 16;
    localparam int         UIRQ_FIFO_DEPTH    = 16;

    typedef struct packed {
        logic       push;
        logic       pop;
        logic [4:0] level;
    } uirq_rx_t;

    typedef struct packed {
        logic       write;
        logic [4:0] level;
    } uirq_tx_t;
endpackage

// ---- rtl/uirq_core.sv ----
`timescale 1ns/1ps
// Interrupt logic of one serial channel
module uirq_core
    import uirq_pkg::*;
#(
    parameter int DEPTH = UIRQ_FIFO_DEPTH
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic       fifo_enable_bit,
    input  wire logic [1:0] rx_trigger_sel,
    input  wire logic [3:0] frame_bits,
    input  wire logic       baud_tick16,
    input  wire uirq_rx_t   rx,
    input  wire uirq_tx_t   tx,
    input  wire logic       line_err_event,
    input  wire logic       line_status_read,
    input  wire logic       modem_change,
    input  wire logic       modem_status_read,
    output logic            rx_data_ready_flag,
    output logic            channel_irq_out
);
    localparam logic [4:0] TRIG0 = 5'd1;
    localparam logic [4:0] TRIG1 = 5'd4;
    localparam logic [4:0] TRIG2 = 5'd8;
    localparam logic [4:0] TRIG3 = 5'd14;

    logic [3:0] mask_q;
    logic       fifo_en_q;
    logic       line_q, modem_q, tout_q, txe_q;
    logic [9:0] tout_cnt_q;
    logic [7:0] char_cnt_q;
    logic       two_held_q;
    logic [7:0] txd_cnt_q;
    logic       txd_wait_q;
    logic [3:0] id_d;
    logic       rx_avail, tx_empty_ev, char_tick, read_id;
    logic [4:0] trig;
    logic [7:0] char_len;

    // Trigger decode used by the receive interrupt
    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'b00: trig_level = TRIG0;
            2'b01: trig_level = TRIG1;
            2'b10: trig_level = TRIG2;
            2'b11: trig_level = TRIG3;
        endcase
    endfunction

    assign trig     = trig_level(rx_trigger_sel);
    assign read_id  = rd && addr == UIRQ_ADDR_ID;
    // Polled mode simply falls out of the mask being all zero
    assign rx_avail = mask_q[0] && rx.level >= trig;
    // Char time = frame bits x 16 ticks, counted on the baud tick
    assign char_len = 8'(frame_bits) * 8'(UIRQ_TICKS_PER_BIT);

    // Mask register, top four bits never stored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_q <= UIRQ_MASK_RESET[3:0];
        end else if (wr && addr == UIRQ_ADDR_MASK) begin
            mask_q <= wdata[3:0];
        end
    end

    // Line status and modem sources; a new event beats the clearing read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_q  <= 1'b0;
            modem_q <= 1'b0;
        end else begin
            line_q  <= line_err_event | (line_q & ~line_status_read);
            modem_q <= modem_change | (modem_q & ~modem_status_read);
        end
    end

    // Data ready follows FIFO occupancy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data_ready_flag <= 1'b0;
        end else begin
            rx_data_ready_flag <= rx.push || (rx.level != 5'd0 && !(rx.pop && rx.level == 5'd1));
        end
    end

    // Character time-out timer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            char_cnt_q <= 8'h00;
            tout_cnt_q <= 10'h000;
            tout_q     <= 1'b0;
        end else if (rx.pop || (rx.push && !tout_q) || rx.level == 5'd0) begin
            char_cnt_q <= 8'h00;
            tout_cnt_q <= 10'h000;
            tout_q     <= 1'b0;
        end else if (baud_tick16 && !tout_q) begin
            if (char_cnt_q + 8'd1 >= char_len) begin
                char_cnt_q <= 8'h00;
                if (tout_cnt_q + 10'd1 >= 10'(UIRQ_TIMEOUT_CHARS)) begin
                    tout_q <= 1'b1;
                end else begin
                    tout_cnt_q <= tout_cnt_q + 10'd1;
                end
            end else begin
                char_cnt_q <= char_cnt_q + 8'd1;
            end
        end
    end

    // Tx empty indication, delayed when fewer than two bytes were held
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            two_held_q <= 1'b0;
            txd_wait_q <= 1'b0;
            txd_cnt_q  <= 8'h00;
        end else if (tx.write || tx.level != 5'd0) begin
            txd_wait_q <= 1'b0;
            txd_cnt_q  <= 8'h00;
            if (tx.level >= 5'd2) begin
                two_held_q <= 1'b1;
            end
        end else if (tx_empty_ev) begin
            two_held_q <= 1'b0;
            txd_wait_q <= 1'b0;
        end else if (!txd_wait_q && !txe_q && fifo_en_q) begin
            txd_wait_q <= 1'b1;
            txd_cnt_q  <= 8'h00;
        end else if (txd_wait_q && baud_tick16) begin
            txd_cnt_q <= txd_cnt_q + 8'd1;
        end
    end

    assign tx_empty_ev = txd_wait_q && (two_held_q ||
                         txd_cnt_q + 8'(UIRQ_STOP_TICKS) >= char_len);
    // Tx empty interrupt source
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fifo_en_q <= 1'b0;
            txe_q     <= 1'b0;
        end else begin
            fifo_en_q <= fifo_enable_bit;
            if (fifo_en_q != fifo_enable_bit) begin
                txe_q <= 1'b1;
            end else if (tx_empty_ev || (!fifo_en_q && tx.level == 5'd0 && !txe_q && tx.write)) begin
                txe_q <= 1'b1;
            end else if (tx.write || (read_id && id_d == UIRQ_ID_TXEMPTY)) begin
                txe_q <= 1'b0;
            end
        end
    end

    // Priority encoder of pending, enabled sources
    always_comb begin
        if (line_q && mask_q[2]) begin
            id_d = UIRQ_ID_LINE;
        end else if (rx_avail) begin
            id_d = UIRQ_ID_RXAVAIL;
        end else if (tout_q && mask_q[0] && fifo_en_q) begin
            id_d = UIRQ_ID_TIMEOUT;
        end else if (txe_q && mask_q[1]) begin
            id_d = UIRQ_ID_TXEMPTY;
        end else if (modem_q && mask_q[3]) begin
            id_d = UIRQ_ID_MODEM;
        end else begin
            id_d = UIRQ_ID_NONE;
        end
    end

    // Registered interrupt output
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            channel_irq_out <= 1'b0;
        end else begin
            channel_irq_out <= (id_d != UIRQ_ID_NONE);
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                UIRQ_ADDR_MASK:   rdata <= {4'h0, mask_q};
                UIRQ_ADDR_ID:     rdata <= {{2{fifo_en_q}}, 2'b00, id_d};
                UIRQ_ADDR_STATUS: rdata <= {3'h0, tout_q, txe_q, rx_data_ready_flag,
                                            modem_q, line_q};
                default:          rdata <= 8'h00;
            endcase
        end
    end

    a_line_first: assert property (@(posedge clock) disable iff (rst)
        (line_q && mask_q[2]) |-> id_d == UIRQ_ID_LINE) else $error("line not first");
    a_irq_follow: assert property (@(posedge clock) disable iff (rst)
        ##1 channel_irq_out == $past(id_d != UIRQ_ID_NONE)) else $error("irq mismatch");
    a_rx_trig: assert property (@(posedge clock) disable iff (rst)
        (mask_q[0] && !(line_q && mask_q[2]) && rx.level >= trig) |-> id_d == UIRQ_ID_RXAVAIL)
        else $error("trigger missed");
    a_pop_clears: assert property (@(posedge clock) disable iff (rst)
        rx.pop |=> !tout_q) else $error("timeout kept");
    a_mask_zero: assert property (@(posedge clock) disable iff (rst)
        mask_q == 4'h0 |-> id_d == UIRQ_ID_NONE) else $error("masked shows id");
    a_line_hold: assert property (@(posedge clock) disable iff (rst)
        line_err_event |=> line_q) else $error("line lost");
    a_modem_set: assert property (@(posedge clock) disable iff (rst)
        modem_change |=> modem_q) else $error("modem lost");
    a_fen_txe: assert property (@(posedge clock) disable iff (rst)
        (fifo_en_q != fifo_enable_bit) |=> txe_q) else $error("no first tx irq");
    a_tout_fifo: assert property (@(posedge clock) disable iff (rst)
        !fifo_en_q |-> id_d != UIRQ_ID_TIMEOUT) else $error("bit3 outside fifo");
    c_timeout: cover property (@(posedge clock) disable iff (rst) id_d == UIRQ_ID_TIMEOUT);
    c_txempty: cover property (@(posedge clock) disable iff (rst) id_d == UIRQ_ID_TXEMPTY);
    c_line:    cover property (@(posedge clock) disable iff (rst) id_d == UIRQ_ID_LINE);
endmodule // uirq_core

// ---- verification/tb_uirq_core.sv ----
`timescale 1ns/1ps
// Self-checking bench for the channel interrupt logic
module tb_uirq_core
    import uirq_pkg::*;
;
    logic       clock, rst, wr, rd, fifo_on, tick, ready_flag, irq;
    logic [1:0] addr, trig_sel;
    logic [7:0] wdata, rdata, d, v;
    logic [7:0] evs;
    uirq_rx_t   rx;
    uirq_tx_t   tx;
    int         failures, n_compared, seed;

    uirq_fifo_model uirq_fifo_model_i (.clock(clock), .rst(rst), .push(evs[0]), .pop(evs[1]),
        .tx_write(evs[6]), .tx_drain(evs[7]), .rx(rx), .tx(tx));
    uirq_core uirq_core_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fifo_enable_bit(fifo_on), .rx_trigger_sel(trig_sel),
        .frame_bits(4'ha), .baud_tick16(tick), .rx(rx), .tx(tx), .line_err_event(evs[2]),
        .line_status_read(evs[3]), .modem_change(evs[4]), .modem_status_read(evs[5]),
        .rx_data_ready_flag(ready_flag), .channel_irq_out(irq));

    // Free-running 50 ns clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [7:0] idv(input logic f, input logic [3:0] c);
        return {f, f, 2'b00, c};
    endfunction

    function automatic int trig(input int s);
        return (s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 14;
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] val);
        @(posedge clock);
        addr <= a;
        wdata <= val;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd_reg(input logic [1:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // One-cycle pulse on a side-band event line
    task automatic ev(input int k);
        @(posedge clock);
        evs[k] <= 1'b1;
        @(posedge clock);
        evs[k] <= 1'b0;
    endtask

    // Two edges let the registered interrupt settle before the read
    task automatic id_is(input logic [7:0] e);
        repeat (2) @(posedge clock);
        rd_reg(UIRQ_ADDR_ID);
        chk("id", d, e);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog far beyond the few thousand cycles the sequence needs
    initial begin
        #1000000;
        failures++;
        tally_and_finish();
    end

    initial begin
        seed = 60230;
        {rst, wr, rd, fifo_on, tick, addr, trig_sel, wdata, evs} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd_reg(UIRQ_ADDR_MASK);
        chk("mask", d, UIRQ_MASK_RESET);
        id_is(idv(1'b0, UIRQ_ID_NONE));
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wr_reg(UIRQ_ADDR_MASK, v);
            rd_reg(UIRQ_ADDR_MASK);
            chk("mask", d, v & 8'h0f);
        end
        wr_reg(UIRQ_ADDR_MASK, 8'h0f);
        @(posedge clock) fifo_on <= 1'b1;
        id_is(idv(1'b1, UIRQ_ID_TXEMPTY));
        id_is(idv(1'b1, UIRQ_ID_NONE));
        // Transmit source masked off so receive codes show alone
        wr_reg(UIRQ_ADDR_MASK, 8'h0d);
        for (int s = 0; s < 4; s++) begin
            @(posedge clock) trig_sel <= s[1:0];
            repeat (trig(s) - 1) ev(0);
            id_is(idv(1'b1, UIRQ_ID_NONE));
            ev(0);
            id_is(idv(1'b1, UIRQ_ID_RXAVAIL));
            chk("ready", {7'h00, ready_flag}, 8'h01);
            chk("irq", {7'h00, irq}, 8'h01);
            ev(1);
            id_is(idv(1'b1, UIRQ_ID_NONE));
            repeat (trig(s) - 1) ev(1);
            repeat (2) @(posedge clock);
            chk("ready", {7'h00, ready_flag}, 8'h00);
        end
        @(posedge clock) trig_sel <= 2'h1;
        repeat (4) ev(0);
        ev(2);
        id_is(idv(1'b1, UIRQ_ID_LINE));
        ev(3);
        id_is(idv(1'b1, UIRQ_ID_RXAVAIL));
        ev(4);
        id_is(idv(1'b1, UIRQ_ID_RXAVAIL));
        repeat (4) ev(1);
        id_is(idv(1'b1, UIRQ_ID_MODEM));
        ev(5);
        id_is(idv(1'b1, UIRQ_ID_NONE));
        // Ten-bit frames: four characters are 640 ticks
        repeat (2) ev(0);
        @(posedge clock) tick <= 1'b1;
        repeat (600) @(posedge clock);
        id_is(idv(1'b1, UIRQ_ID_NONE));
        repeat (60) @(posedge clock);
        id_is(idv(1'b1, UIRQ_ID_TIMEOUT));
        ev(1);
        id_is(idv(1'b1, UIRQ_ID_NONE));
        wr_reg(UIRQ_ADDR_MASK, 8'h00);
        repeat (700) @(posedge clock);
        id_is(idv(1'b1, UIRQ_ID_NONE));
        chk("irq", {7'h00, irq}, 8'h00);
        // Status: time-out, tx empty and data ready all stand with only mask bit 1 set
        wr_reg(UIRQ_ADDR_MASK, 8'h02);
        rd_reg(UIRQ_ADDR_STATUS);
        chk("status", d, 8'h1c);
        // A holding write clears tx empty at once
        ev(6);
        id_is(idv(1'b1, UIRQ_ID_NONE));
        // Only one byte was held, so the empty indication waits most of a character
        ev(7);
        id_is(idv(1'b1, UIRQ_ID_NONE));
        repeat (150) @(posedge clock);
        id_is(idv(1'b1, UIRQ_ID_TXEMPTY));
        id_is(idv(1'b1, UIRQ_ID_NONE));
        wr_reg(UIRQ_ADDR_MASK, 8'h00);
        @(posedge clock) fifo_on <= 1'b0;
        id_is(idv(1'b0, UIRQ_ID_NONE));
        tally_and_finish();
    end
endmodule // tb_uirq_core

// ---- verification/uirq_fifo_model.sv ----
`timescale 1ns/1ps
// Stand-in for the receive and transmit FIFO counters that sit around the channel
module uirq_fifo_model
    import uirq_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic push,
    input  wire logic pop,
    input  wire logic tx_write,
    input  wire logic tx_drain,
    output uirq_rx_t  rx,
    output uirq_tx_t  tx
);
    logic [4:0] rx_level_q;
    logic [4:0] tx_level_q;

    // Receive fill; a push into a full FIFO is lost, as an overrun would be
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_level_q <= 5'h00;
        end else if (push && !pop && rx_level_q < 5'h10) begin
            rx_level_q <= rx_level_q + 5'h01;
        end else if (pop && !push && rx_level_q != 5'h00) begin
            rx_level_q <= rx_level_q - 5'h01;
        end
    end

    // Host loads at most sixteen characters per service, so the count stops there
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_level_q <= 5'h00;
        end else if (tx_write && tx_level_q < 5'h10) begin
            tx_level_q <= tx_level_q + 5'h01;
        end else if (tx_drain && tx_level_q != 5'h00) begin
            tx_level_q <= tx_level_q - 5'h01;
        end
    end

    // Pulses pass straight through; levels lag the pulse by one edge
    assign rx = '{push: push, pop: pop, level: rx_level_q};
    assign tx = '{write: tx_write, level: tx_level_q};
endmodule // uirq_fifo_model
